// ==== design/usb_endpoint_fifo_access.sv ====
`timescale 1ns/10ps
module usb_endpoint_fifo_access #(
   parameter int DEPTH = 32
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [2:0]  sie_endpoint,
   input  wire logic        sie_write,
   input  wire logic [7:0]  sie_wdata,
   input  wire logic        sie_read,
   output logic [7:0]       sie_rdata,
   input  wire logic        sie_packet_end,
   input  wire logic        sie_in_done,
   input  wire logic        sie_out_nak_query,
   input  wire logic        sie_isochronous,
   output logic             sie_out_nak,
   output logic [6:0]       packet_ready_flag,
   output logic             irq
);
   localparam int N  = ep_fifo_pkg::NUM_EP;
   localparam int CW = ep_fifo_pkg::COUNT_WIDTH;

   // ************************************************************
   // register state
   // ************************************************************
   logic [ep_fifo_pkg::SEL_WIDTH-1:0] selected_endpoint_index;
   logic [N-1:0] endpoint_fifo_reset_bits;
   logic [N-1:0] transmit_complete_flag;
   logic [N-1:0] out_received_bank_zero;
   logic [N-1:0] irq_status;
   logic [N-1:0] irq_mask;
   logic [ep_fifo_pkg::SEL_WIDTH-1:0] next_sel;
   logic [N-1:0] next_rst;
   logic [N-1:0] next_ready;
   logic [N-1:0] next_txc;
   logic [N-1:0] next_outb0;
   logic [N-1:0] next_status;
   logic [N-1:0] next_mask;

   // ************************************************************
   // axi4-lite handshake
   // ************************************************************
   logic        aw_held;
   logic        w_held;
   logic [11:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        next_aw_held;
   logic        next_w_held;
   logic [11:0] next_aw_addr;
   logic [31:0] next_w_data;
   logic [3:0]  next_w_strb;
   logic        next_bvalid;
   logic [1:0]  next_bresp;
   logic        next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0]  next_rresp;
   logic        wr_fire;
   logic        rd_fire;
   logic        wr_lane0;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   // a write executes once both halves are captured
   assign wr_fire  = aw_held && w_held && !s_axi_bvalid;
   assign rd_fire  = s_axi_arvalid && s_axi_arready;
   assign wr_lane0 = wr_fire && w_strb[0];

   // ************************************************************
   // endpoint stores
   // ************************************************************
   logic [7:0]    ep_rdata [N];
   logic [CW-1:0] ep_count [N];
   logic [CW:0]   ep_level [N];
   logic [N-1:0]  fw_wr;
   logic [N-1:0]  fw_rd;

   genvar g;
   generate
      for (g = 0; g < N; g++)
      begin : gen_ep
         ep_fifo_slot #(
            .DEPTH (DEPTH),
            .CW    (CW)
         ) u_slot (
            .aclk                (aclk),
            .aresetn             (aresetn),
            .fifo_reset          (endpoint_fifo_reset_bits[g]),
            .fw_write            (fw_wr[g]),
            .fw_read             (fw_rd[g]),
            .fw_wdata            (w_data[7:0]),
            .sie_write           (sie_write && sie_endpoint == 3'(g)),
            .sie_read            (sie_read && sie_endpoint == 3'(g)),
            .sie_wdata           (sie_wdata),
            .sie_packet_end      (sie_packet_end && sie_endpoint == 3'(g)),
            .rdata               (ep_rdata[g]),
            .received_byte_total (ep_count[g]),
            .level               (ep_level[g])
         );
         // data port steers to the selected store only
         assign fw_wr[g] = wr_lane0 && aw_addr == ep_fifo_pkg::ADDR_DATA_PORT
                           && selected_endpoint_index == 3'(g);
         assign fw_rd[g] = rd_fire
                           && s_axi_araddr == ep_fifo_pkg::ADDR_DATA_PORT
                           && selected_endpoint_index == 3'(g);
      end
   endgenerate

   logic sel_ok;
   logic sie_ok;
   assign sel_ok = selected_endpoint_index < 3'(N);
   assign sie_ok = sie_endpoint < 3'(N);
   assign sie_rdata = sie_ok ? ep_rdata[sie_endpoint] : 8'h00;
   // non-isochronous out packets refused while the endpoint's bank zero received flag is set
   assign sie_out_nak = sie_out_nak_query && sie_ok && !sie_isochronous
                        && out_received_bank_zero[sie_endpoint];
   assign irq = |(irq_status & irq_mask);

   // ************************************************************
   // bus channel next values
   // ************************************************************
   always_comb
   begin
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_aw_addr = aw_addr;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      next_bvalid  = s_axi_bvalid;
      next_bresp   = s_axi_bresp;
      next_rvalid  = s_axi_rvalid;
      next_rdata   = s_axi_rdata;
      next_rresp   = s_axi_rresp;
      if (s_axi_awvalid && s_axi_awready)
      begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (wr_fire)
      begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = ep_fifo_pkg::RESP_OKAY;
         case (aw_addr)
            ep_fifo_pkg::ADDR_DATA_PORT,
            ep_fifo_pkg::ADDR_RESET_BITS,
            ep_fifo_pkg::ADDR_SELECT,
            ep_fifo_pkg::ADDR_CONTROL,
            ep_fifo_pkg::ADDR_IRQ_STATUS,
            ep_fifo_pkg::ADDR_IRQ_MASK,
            ep_fifo_pkg::ADDR_COUNT_LOW,
            ep_fifo_pkg::ADDR_COUNT_HIGH: next_bresp = ep_fifo_pkg::RESP_OKAY;
            default: next_bresp = ep_fifo_pkg::RESP_SLVERR;
         endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
         next_bvalid = 1'b0;
      if (rd_fire)
      begin
         next_rvalid = 1'b1;
         next_rresp  = ep_fifo_pkg::RESP_OKAY;
         next_rdata  = 32'h0000_0000;
         case (s_axi_araddr)
            ep_fifo_pkg::ADDR_DATA_PORT:
               next_rdata = sel_ok ? 32'(ep_rdata[selected_endpoint_index])
                                   : ep_fifo_pkg::READ_UNDEF;
            ep_fifo_pkg::ADDR_COUNT_LOW:
               next_rdata = sel_ok ? {24'h00_0000,
                  ep_count[selected_endpoint_index][7:0]} : '0;
            ep_fifo_pkg::ADDR_COUNT_HIGH:
               next_rdata = sel_ok ? {29'h0000_0000,
                  ep_count[selected_endpoint_index][CW-1:8]} : '0;
            ep_fifo_pkg::ADDR_RESET_BITS:
               next_rdata = {25'h000_0000, endpoint_fifo_reset_bits};
            ep_fifo_pkg::ADDR_SELECT:
               next_rdata = {29'h0000_0000, selected_endpoint_index};
            ep_fifo_pkg::ADDR_CONTROL:
               next_rdata = sel_ok ? {29'h0000_0000,
                  transmit_complete_flag[selected_endpoint_index],
                  out_received_bank_zero[selected_endpoint_index],
                  packet_ready_flag[selected_endpoint_index]} : '0;
            ep_fifo_pkg::ADDR_IRQ_STATUS:
               next_rdata = {25'h000_0000, irq_status};
            ep_fifo_pkg::ADDR_IRQ_MASK:
               next_rdata = {25'h000_0000, irq_mask};
            default:
               next_rresp = ep_fifo_pkg::RESP_SLVERR;
         endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
         next_rvalid = 1'b0;
   end

   // ************************************************************
   // register next values
   // ************************************************************
   always_comb
   begin
      next_sel    = selected_endpoint_index;
      next_rst    = endpoint_fifo_reset_bits;
      next_ready  = packet_ready_flag;
      next_txc    = transmit_complete_flag;
      next_outb0  = out_received_bank_zero;
      next_status = irq_status;
      next_mask   = irq_mask;
      if (wr_lane0)
      begin
         case (aw_addr)
            ep_fifo_pkg::ADDR_SELECT:
               next_sel = w_data[ep_fifo_pkg::SEL_WIDTH-1:0];
            ep_fifo_pkg::ADDR_RESET_BITS:
               next_rst = w_data[N-1:0];
            ep_fifo_pkg::ADDR_IRQ_MASK:
               next_mask = w_data[N-1:0];
            ep_fifo_pkg::ADDR_IRQ_STATUS:
               next_status = irq_status & ~w_data[N-1:0];
            ep_fifo_pkg::ADDR_CONTROL:
               if (sel_ok)
               begin
                  // writing zero clears a flag; ready is set by a one
                  if (w_data[ep_fifo_pkg::CTRL_READY_BIT])
                     next_ready[selected_endpoint_index] = 1'b1;
                  if (!w_data[ep_fifo_pkg::CTRL_OUTB0_BIT])
                     next_outb0[selected_endpoint_index] = 1'b0;
                  if (!w_data[ep_fifo_pkg::CTRL_TXC_BIT])
                     next_txc[selected_endpoint_index] = 1'b0;
               end
            default:
               next_sel = selected_endpoint_index;
         endcase
      end
      // hardware sets after the clear so a same-cycle event wins
      if (sie_ok && sie_in_done && packet_ready_flag[sie_endpoint])
      begin
         next_ready[sie_endpoint]  = 1'b0;
         next_txc[sie_endpoint]    = 1'b1;
         next_status[sie_endpoint] = 1'b1;
      end
      if (sie_ok && sie_packet_end)
      begin
         next_outb0[sie_endpoint]  = 1'b1;
         next_status[sie_endpoint] = 1'b1;
      end
      // a held fifo reset also drops that endpoint's ready and bank zero flags
      next_ready = next_ready & ~endpoint_fifo_reset_bits;
      next_outb0 = next_outb0 & ~endpoint_fifo_reset_bits;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held                  <= 1'b0;
         w_held                   <= 1'b0;
         aw_addr                  <= 12'h000;
         w_data                   <= 32'h0000_0000;
         w_strb                   <= 4'h0;
         s_axi_bvalid             <= 1'b0;
         s_axi_bresp              <= 2'h0;
         s_axi_rvalid             <= 1'b0;
         s_axi_rdata              <= 32'h0000_0000;
         s_axi_rresp              <= 2'h0;
         selected_endpoint_index  <= 3'h0;
         endpoint_fifo_reset_bits <= ep_fifo_pkg::RESET_BITS_RST;
         packet_ready_flag        <= 7'h00;
         transmit_complete_flag   <= 7'h00;
         out_received_bank_zero   <= 7'h00;
         irq_status               <= 7'h00;
         irq_mask                 <= 7'h00;
      end
      else
      begin
         aw_held                  <= next_aw_held;
         w_held                   <= next_w_held;
         aw_addr                  <= next_aw_addr;
         w_data                   <= next_w_data;
         w_strb                   <= next_w_strb;
         s_axi_bvalid             <= next_bvalid;
         s_axi_bresp              <= next_bresp;
         s_axi_rvalid             <= next_rvalid;
         s_axi_rdata              <= next_rdata;
         s_axi_rresp              <= next_rresp;
         selected_endpoint_index  <= next_sel;
         endpoint_fifo_reset_bits <= next_rst;
         packet_ready_flag        <= next_ready;
         transmit_complete_flag   <= next_txc;
         out_received_bank_zero   <= next_outb0;
         irq_status               <= next_status;
         irq_mask                 <= next_mask;
      end
   end
endmodule : usb_endpoint_fifo_access

// ==== design/ep_fifo_pkg.sv ====
package ep_fifo_pkg;
   // register byte addresses (printed offsets are not word multiples)
   localparam int unsigned IDX_DATA_PORT  = 32'h0000_00CF;
   localparam int unsigned IDX_RESET_BITS = 32'h0000_00D5;
   localparam int unsigned IDX_COUNT_LOW  = 32'h0000_00E2;
   localparam int unsigned IDX_COUNT_HIGH = 32'h0000_00E3;
   localparam int unsigned IDX_SELECT     = 32'h0000_00C7;
   localparam int unsigned IDX_CONTROL    = 32'h0000_00C8;
   localparam int unsigned IDX_IRQ_STATUS = 32'h0000_00C9;
   localparam int unsigned IDX_IRQ_MASK   = 32'h0000_00CA;
   localparam logic [11:0] ADDR_DATA_PORT  = 12'(IDX_DATA_PORT * 4);
   localparam logic [11:0] ADDR_RESET_BITS = 12'(IDX_RESET_BITS * 4);
   localparam logic [11:0] ADDR_COUNT_LOW  = 12'(IDX_COUNT_LOW * 4);
   localparam logic [11:0] ADDR_COUNT_HIGH = 12'(IDX_COUNT_HIGH * 4);
   localparam logic [11:0] ADDR_SELECT     = 12'(IDX_SELECT * 4);
   localparam logic [11:0] ADDR_CONTROL    = 12'(IDX_CONTROL * 4);
   localparam logic [11:0] ADDR_IRQ_STATUS = 12'(IDX_IRQ_STATUS * 4);
   localparam logic [11:0] ADDR_IRQ_MASK   = 12'(IDX_IRQ_MASK * 4);
   // field layout
   localparam int NUM_EP          = 7;
   localparam int SEL_WIDTH       = 3;
   localparam int COUNT_WIDTH     = 11;
   localparam int COUNT_HIGH_BITS = 3;
   localparam int CTRL_READY_BIT  = 0;
   localparam int CTRL_OUTB0_BIT  = 1;
   localparam int CTRL_TXC_BIT    = 2;
   localparam logic [6:0]  RESET_BITS_RST = 7'h7F;
   localparam logic [31:0] READ_UNDEF     = 32'h0000_0000;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage : ep_fifo_pkg

// ==== design/ep_fifo_slot.sv ====
`timescale 1ns/10ps
// one endpoint byte store with its own pointers and count
module ep_fifo_slot #(
   parameter int DEPTH = 32,
   parameter int CW    = 11
) (
   input  wire logic          aclk,
   input  wire logic          aresetn,
   input  wire logic          fifo_reset,
   input  wire logic          fw_write,
   input  wire logic          fw_read,
   input  wire logic [7:0]    fw_wdata,
   input  wire logic          sie_write,
   input  wire logic          sie_read,
   input  wire logic [7:0]    sie_wdata,
   input  wire logic          sie_packet_end,
   output logic      [7:0]    rdata,
   output logic      [CW-1:0] received_byte_total,
   output logic      [CW:0]   level
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || DEPTH > 2**(CW-1) || (DEPTH & (DEPTH-1)) != 0)
      $error("ep_fifo_slot: bad depth");

   logic [7:0]    store [DEPTH];
   logic [CW:0]   wr_ptr;
   logic [CW:0]   rd_ptr;
   logic [CW-1:0] pkt_count;
   logic [CW:0]   next_wr_ptr;
   logic [CW:0]   next_rd_ptr;
   logic [CW-1:0] next_pkt_count;
   logic          do_write;
   logic          do_read;
   logic [7:0]    wbyte;

   assign level  = wr_ptr - rd_ptr;
   assign wbyte  = fw_write ? fw_wdata : sie_wdata;
   // full store drops writes; empty reads give whatever sits there
   assign do_write = (fw_write | sie_write) & (level < (CW+1)'(DEPTH));
   assign do_read  = fw_read | sie_read;
   assign rdata    = store[rd_ptr[AW-1:0]];
   assign received_byte_total = pkt_count;

   // pointer and count next values
   always_comb
   begin
      next_wr_ptr    = wr_ptr;
      next_rd_ptr    = rd_ptr;
      next_pkt_count = pkt_count;
      if (fifo_reset)
      begin
         next_wr_ptr    = '0;
         next_rd_ptr    = '0;
         next_pkt_count = '0;
      end
      else
      begin
         if (do_write)
            next_wr_ptr = wr_ptr + 1'b1;
         if (do_read && level != '0)
            next_rd_ptr = rd_ptr + 1'b1;
         if (sie_packet_end)
            next_pkt_count = level[CW-1:0] + CW'(do_write);
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wr_ptr    <= '0;
         rd_ptr    <= '0;
         pkt_count <= '0;
      end
      else
      begin
         wr_ptr    <= next_wr_ptr;
         rd_ptr    <= next_rd_ptr;
         pkt_count <= next_pkt_count;
      end
   end

   // byte store, no reset: contents are undefined until written
   always_ff @(posedge aclk)
   begin
      if (do_write && !fifo_reset)
         store[wr_ptr[AW-1:0]] <= wbyte;
   end
endmodule : ep_fifo_slot

// ==== tb/usb_endpoint_fifo_access_properties.sv ====
`timescale 1ns/10ps
// ****************************************
// bus handshake and endpoint flag checks
// ****************************************
module usb_endpoint_fifo_access_properties (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [2:0]  sie_endpoint,
   input wire logic        sie_in_done,
   input wire logic        sie_out_nak_query,
   input wire logic        sie_isochronous,
   input wire logic        sie_out_nak,
   input wire logic [6:0]  packet_ready_flag,
   input wire logic        irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // answers stand until taken, so the master never loses a response
   a_bvalid_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer changed before taken");
   a_rvalid_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read answer changed before taken");
   a_write_latency: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write answer not two cycles after capture");
   a_read_latency: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_busy_blocks: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   a_ar_blocks: assert property (
      s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   a_nak_cause: assert property (
      sie_out_nak |-> sie_out_nak_query && !sie_isochronous)
      else $error("nak without query or on isochronous");
   a_ready_clear: assert property (
      sie_in_done && sie_endpoint < 3'h7 && packet_ready_flag[sie_endpoint]
      |=> !packet_ready_flag[$past(sie_endpoint)])
      else $error("packet ready not cleared after send");
   a_reset_idle: assert property (
      $rose(aresetn) |-> !irq && packet_ready_flag == 7'h00)
      else $error("flags or irq set after reset");
   c_slave_error: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
   c_nak_given: cover property (sie_out_nak);
   c_irq_raised: cover property (irq);
endmodule : usb_endpoint_fifo_access_properties

bind usb_endpoint_fifo_access usb_endpoint_fifo_access_properties chk (.*);

// ==== tb/sie_model.sv ====
`timescale 1ns/10ps
// ****************************************
// serial engine side of the endpoint fifos
// ****************************************
module sie_model (
   input  wire logic       aclk,
   output logic      [2:0] sie_endpoint,
   output logic            sie_write,
   output logic      [7:0] sie_wdata,
   output logic            sie_read,
   input  wire logic [7:0] sie_rdata,
   output logic            sie_packet_end,
   output logic            sie_in_done,
   output logic            sie_out_nak_query,
   output logic            sie_isochronous,
   input  wire logic       sie_out_nak
);
   initial
   begin
      {sie_endpoint, sie_write, sie_wdata, sie_read} = '0;
      {sie_packet_end, sie_in_done, sie_out_nak_query, sie_isochronous} = '0;
   end
   // one byte a cycle; data line shows the inverse once released
   task automatic push(input logic [2:0] ep, input int n,
                       input logic [7:0] base);
      for (int i = 0; i < n; i++)
      begin
         @(posedge aclk);
         sie_endpoint   <= ep;
         sie_write      <= 1'b1;
         sie_wdata      <= base + 8'(i);
         sie_packet_end <= (i == n - 1);
      end
      @(posedge aclk);
      sie_write      <= 1'b0;
      sie_packet_end <= 1'b0;
      sie_wdata      <= ~sie_wdata;
   endtask : push
   // head byte is sampled at the popping edge
   task automatic pop(input logic [2:0] ep, output logic [7:0] d);
      @(posedge aclk);
      sie_endpoint <= ep;
      sie_read     <= 1'b1;
      @(posedge aclk);
      d = sie_rdata;
      sie_read <= 1'b0;
   endtask : pop
   // host acknowledge of an in packet
   task automatic in_done(input logic [2:0] ep);
      @(posedge aclk);
      sie_endpoint <= ep;
      sie_in_done  <= 1'b1;
      @(posedge aclk);
      sie_in_done <= 1'b0;
   endtask : in_done
   // asks whether an out packet would be refused
   task automatic query(input logic [2:0] ep, input logic iso,
                        output logic nak);
      @(posedge aclk);
      sie_endpoint      <= ep;
      sie_out_nak_query <= 1'b1;
      sie_isochronous   <= iso;
      @(posedge aclk);
      nak = sie_out_nak;
      sie_out_nak_query <= 1'b0;
   endtask : query
endmodule : sie_model

// ==== tb/usb_endpoint_fifo_access_tb.sv ====
`timescale 1ns/10ps
// ****************************************
// firmware side bench
// ****************************************
module usb_endpoint_fifo_access_tb;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid, irq, sie_out_nak;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [2:0]  sie_endpoint;
   logic        sie_write, sie_read, sie_packet_end, sie_in_done;
   logic        sie_out_nak_query, sie_isochronous;
   logic [7:0]  sie_wdata, sie_rdata, b;
   logic [6:0]  packet_ready_flag;
   logic [1:0]  r;
   logic [31:0] d;
   int          miscompares = 0, checks_done = 0;
   // 256 deep so a full packet reaches count bit 8
   usb_endpoint_fifo_access #(.DEPTH(256)) uut (.*);
   sie_model sie (.*);
   always #50 aclk = ~aclk;
   task automatic final_report();
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : final_report
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
         miscompares++;
      end
   endtask : cmp
   task automatic hang();
      miscompares++;
      final_report();
   endtask : hang
   // both write halves offered together, each released when taken
   task automatic axi_write(input logic [11:0] a, input logic [31:0] v,
                            output logic [1:0] resp);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      if (n == 40) hang();
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axi_write
   task automatic axi_read(input logic [11:0] a, output logic [31:0] v,
                           output logic [1:0] resp);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      if (n == 40) hang();
      v = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axi_read
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      logic [1:0] rs;
      axi_write(a, v, rs);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] v;
      logic [1:0]  rs;
      axi_read(a, v, rs);
      cmp(v, exp);
   endtask : rd
   task automatic t_reset_state();
      rd(ep_fifo_pkg::ADDR_RESET_BITS, 32'h7F);
      rd(ep_fifo_pkg::ADDR_COUNT_HIGH, 32'h0);
      wr(ep_fifo_pkg::ADDR_RESET_BITS, 32'h0);
      rd(ep_fifo_pkg::ADDR_RESET_BITS, 32'h0);
      $display("reset state done");
   endtask : t_reset_state
   task automatic t_data_port();
      wr(ep_fifo_pkg::ADDR_SELECT, 32'h2);
      for (int i = 0; i < 3; i++) wr(ep_fifo_pkg::ADDR_DATA_PORT, 32'hA0 + i);
      for (int i = 0; i < 3; i++)
      begin
         sie.pop(3'h2, b);
         cmp(b, 32'hA0 + i);
      end
      sie.push(3'h2, 5, 8'h10);
      rd(ep_fifo_pkg::ADDR_COUNT_LOW, 32'h5);
      rd(ep_fifo_pkg::ADDR_DATA_PORT, 32'h10);
      rd(ep_fifo_pkg::ADDR_DATA_PORT, 32'h11);
      wr(ep_fifo_pkg::ADDR_SELECT, 32'h3);
      rd(ep_fifo_pkg::ADDR_COUNT_LOW, 32'h0);
      $display("data port done");
   endtask : t_data_port
   task automatic t_long_packet();
      sie.push(3'h4, 262, 8'h00);
      wr(ep_fifo_pkg::ADDR_SELECT, 32'h4);
      rd(ep_fifo_pkg::ADDR_COUNT_LOW, 32'h0);
      rd(ep_fifo_pkg::ADDR_COUNT_HIGH, 32'h1);
      rd(ep_fifo_pkg::ADDR_DATA_PORT, 32'h0);
      $display("long packet done");
   endtask : t_long_packet
   task automatic t_fifo_reset();
      wr(ep_fifo_pkg::ADDR_RESET_BITS, 32'h10);
      rd(ep_fifo_pkg::ADDR_COUNT_LOW, 32'h0);
      wr(ep_fifo_pkg::ADDR_DATA_PORT, 32'h77); // dropped while held
      wr(ep_fifo_pkg::ADDR_SELECT, 32'h2);
      rd(ep_fifo_pkg::ADDR_COUNT_LOW, 32'h5);
      wr(ep_fifo_pkg::ADDR_RESET_BITS, 32'h0);
      sie.push(3'h4, 1, 8'h42);
      wr(ep_fifo_pkg::ADDR_SELECT, 32'h4);
      rd(ep_fifo_pkg::ADDR_COUNT_LOW, 32'h1);
      sie.pop(3'h4, b);
      cmp(b, 32'h42);
      $display("fifo reset done");
   endtask : t_fifo_reset
   // unmasked then masked completion of an in packet
   task automatic t_transmit();
      wr(ep_fifo_pkg::ADDR_SELECT, 32'h5);
      wr(ep_fifo_pkg::ADDR_IRQ_MASK, 32'h20);
      wr(ep_fifo_pkg::ADDR_CONTROL, 32'h1);
      cmp(packet_ready_flag, 32'h20);
      sie.in_done(3'h5);
      @(negedge aclk);
      cmp(packet_ready_flag, 32'h00);
      cmp(irq, 32'h1);
      rd(ep_fifo_pkg::ADDR_CONTROL, 32'h4);
      wr(ep_fifo_pkg::ADDR_IRQ_STATUS, 32'h20);
      @(negedge aclk);
      cmp(irq, 32'h0);
      wr(ep_fifo_pkg::ADDR_IRQ_MASK, 32'h0);
      wr(ep_fifo_pkg::ADDR_CONTROL, 32'h1);
      sie.in_done(3'h5);
      @(negedge aclk);
      cmp(irq, 32'h0);
      $display("transmit done");
   endtask : t_transmit
   task automatic t_out_nak();
      sie.push(3'h6, 2, 8'h30);
      sie.query(3'h6, 1'b0, b[0]);
      cmp(b[0], 32'h1);
      sie.query(3'h6, 1'b1, b[0]);
      cmp(b[0], 32'h0);
      wr(ep_fifo_pkg::ADDR_SELECT, 32'h6);
      wr(ep_fifo_pkg::ADDR_CONTROL, 32'h0);
      sie.query(3'h6, 1'b0, b[0]);
      cmp(b[0], 32'h0);
      $display("out nak done");
   endtask : t_out_nak
   // an address outside the map is refused on both paths
   task automatic t_unmapped();
      axi_write(12'hFFC, 32'h0, r);
      cmp(r, ep_fifo_pkg::RESP_SLVERR);
      axi_read(12'hFFC, d, r);
      cmp(r, ep_fifo_pkg::RESP_SLVERR);
      $display("unmapped done");
   endtask : t_unmapped
   initial
   begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset_state();
      t_data_port();
      t_long_packet();
      t_fifo_reset();
      t_transmit();
      t_out_nak();
      t_unmapped();
      final_report();
   end
endmodule : usb_endpoint_fifo_access_tb
